/* File: rtl/iqm_map.svh */
// register offsets, field positions, reset values and arithmetic constants
`ifndef IQM_MAP_SVH
`define IQM_MAP_SVH
`define IQM_ADDR_FRAME_CFG 8'h22
`define IQM_ADDR_ROLLOFF 8'h27
`define IQM_ADDR_HANDSHAKE 8'h30
`define IQM_ADDR_TW0 8'h31
`define IQM_ADDR_TW1 8'h32
`define IQM_ADDR_TW2 8'h33
`define IQM_ADDR_TW3 8'h34
`define IQM_ADDR_ANGLE0 8'h37
`define IQM_ADDR_ANGLE1 8'h38
`define IQM_ADDR_IOFS0 8'h3B
`define IQM_ADDR_IOFS1 8'h3C
`define IQM_ADDR_QOFS0 8'h3D
`define IQM_ADDR_QOFS1 8'h3E
`define IQM_ADDR_IGAIN 8'h3F
`define IQM_ADDR_QGAIN 8'h40
`define IQM_BIT_SW_REQ 0
`define IQM_BIT_SW_ACK 1
`define IQM_BIT_FRAME_ACK 6
`define IQM_BIT_CONT_FRAME 2
`define IQM_BIT_ROLLOFF_EN 7
`define IQM_FRAME_MODE_OSC 2'h1
`define IQM_FRAME_MODE_BOTH 2'h2
`define IQM_GAIN_RESET 6'h20
`define IQM_GAIN_SHIFT 5
`define IQM_ANGLE_SHIFT 14
`define IQM_CARRIER_SHIFT 14
`define IQM_FIR_SHIFT 8
`define IQM_FIR_C1 40'sh0000000001
`define IQM_FIR_C2 40'sh0000000004
`define IQM_FIR_C3 40'sh0000000010
`define IQM_FIR_C4 40'sh00000000C0
`define IQM_QUARTER_STEP 6'h10
`define IQM_PIPE_LATENCY 4
`endif

/* File: rtl/iqm_pkg.sv */
// types shared by the quadrature correction path
package iqm_pkg;
  typedef struct packed {
    logic signed [15:0] i;
    logic signed [15:0] q;
  } iqm_sample_type;
  typedef enum logic [1:0] {
    IQM_MIX_BYPASS,
    IQM_MIX_COARSE,
    IQM_MIX_OSC
  } iqm_mix_mode_type;
endpackage

/* File: rtl/iqm_path.sv */
// transmit quadrature path: mixers, inverse sinc, gain, phase and dc offset
// Behaviour
// - coarse mode rotates I/Q by a quarter turn per clock, carrier at fs/4
// - oscillator mode mixes samples with cos/sin carrier and sums products
// - 32-bit tuning word lives in registers 0x31 to 0x34
// - oscillator steps once per converter clock, covering dc to half clock
// - tuning word is a two's complement phase increment over 2^32
// - tuning word writes stay pending until an update trigger
// - request bit rising from 0 to 1 loads the pending word
// - acknowledge bit sets once the oscillator took the new word
// - request bit falling clears acknowledge and re-arms the update
// - frame rising edge loads the word when frame mode includes oscillator
// - one-shot frame mode updates once from one valid frame pulse
// - frame acknowledge bit sets after a frame-triggered update
// - I and Q have separate 6-bit gain codes
// - gain code maps linearly to 0..63/32 in 1/32 steps, 0x20 unity
// - 13-bit angle code tilts I/Q angle about +/-14 degrees
// - angle code is two's complement, 0x0FFF positive, 0x1000 negative
// - separate 16-bit dc offsets added to I and Q
// - inverse sinc is symmetric seven-tap FIR -1 +4 -16 +192
// - inverse sinc bypassed after reset, inserted when enable bit set
// - dc offset stage always present, constant latency, offsets reset zero
`timescale 1ns/1ps
`include "iqm_map.svh"
module iqm_path import iqm_pkg::*; (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // configuration registers
  input wire logic cfg_wr_en,
  input wire logic [7:0] cfg_addr,
  input wire logic [7:0] cfg_wr_data,
  output logic [7:0] cfg_rd_data,
  // frame pin and mixer selection
  input wire logic frame_in,
  input iqm_mix_mode_type mix_mode,
  // sample streams
  input wire logic in_valid,
  input iqm_sample_type in_sample,
  output logic out_valid,
  output iqm_sample_type out_sample
);

  function automatic logic signed [15:0] sat16(input logic signed [39:0] v);
    if (v > 40'sh0000007FFF) begin
      return 16'sh7FFF;
    end else if (v < -40'sh0000008000) begin
      return 16'sh8000;
    end
    return v[15:0];
  endfunction

  function automatic logic signed [15:0] quarter_sine(input logic [4:0] k);
    case (k)
      5'h00: return 16'sh0000;
      5'h01: return 16'sh0646;
      5'h02: return 16'sh0C7C;
      5'h03: return 16'sh1294;
      5'h04: return 16'sh187E;
      5'h05: return 16'sh1E2B;
      5'h06: return 16'sh238E;
      5'h07: return 16'sh289A;
      5'h08: return 16'sh2D41;
      5'h09: return 16'sh3179;
      5'h0A: return 16'sh3537;
      5'h0B: return 16'sh3871;
      5'h0C: return 16'sh3B21;
      5'h0D: return 16'sh3D3F;
      5'h0E: return 16'sh3EC5;
      5'h0F: return 16'sh3FB1;
      5'h10: return 16'sh3FFF;
      default: return 16'sh0000;
    endcase
  endfunction

  // full circle from a quarter table by symmetry
  function automatic logic signed [15:0] sine_of(input logic [5:0] p);
    logic [4:0] k;
    logic signed [15:0] mag;
    k = p[4] ? (5'h10 - {1'b0, p[3:0]}) : {1'b0, p[3:0]};
    mag = quarter_sine(k);
    return p[5] ? -mag : mag;
  endfunction

  function automatic logic signed [15:0] fir7(input logic [6:0][15:0] t);
    logic signed [39:0] acc;
    acc = -`IQM_FIR_C1 * (40'(signed'(t[0])) + 40'(signed'(t[6])))
        + `IQM_FIR_C2 * (40'(signed'(t[1])) + 40'(signed'(t[5])))
        - `IQM_FIR_C3 * (40'(signed'(t[2])) + 40'(signed'(t[4])))
        + `IQM_FIR_C4 * 40'(signed'(t[3]));
    return sat16(acc >>> `IQM_FIR_SHIFT);
  endfunction

  function automatic logic signed [15:0] gain_of(input logic signed [15:0] x,
                                                 input logic [5:0] code);
    logic signed [39:0] prod;
    prod = 40'(x) * 40'(signed'({1'b0, code}));
    return sat16(prod >>> `IQM_GAIN_SHIFT);
  endfunction

  // configuration state
  logic [2:0] frame_cfg_reg;
  logic rolloff_comp_enable_reg;
  logic sw_update_request_reg;
  logic sw_update_acknowledge_reg;
  logic frame_update_acknowledge_reg;
  logic frame_armed_reg;
  logic [31:0] tuning_word_reg;
  logic [31:0] active_word_reg;
  logic [31:0] phase_acc_reg;
  logic [12:0] quadrature_angle_code_reg;
  logic [15:0] i_offset_value_reg;
  logic [15:0] q_offset_value_reg;
  logic [5:0] i_gain_code_reg;
  logic [5:0] q_gain_code_reg;
  logic [7:0] cfg_rd_data_reg;
  // frame pin synchroniser and edge history
  logic frame_meta_reg;
  logic frame_sync_reg;
  logic frame_prev_reg;
  // datapath pipeline
  logic [1:0] quarter_reg;
  logic s1_valid_reg;
  logic s2_valid_reg;
  logic s3_valid_reg;
  logic s4_valid_reg;
  iqm_sample_type s1_sample_reg;
  iqm_sample_type s2_sample_reg;
  iqm_sample_type s3_sample_reg;
  iqm_sample_type s4_sample_reg;
  logic [6:0][15:0] i_tap_reg;
  logic [6:0][15:0] q_tap_reg;

  // write decode
  wire wr_frame_cfg = cfg_wr_en && cfg_addr == `IQM_ADDR_FRAME_CFG;
  wire wr_rolloff = cfg_wr_en && cfg_addr == `IQM_ADDR_ROLLOFF;
  wire wr_handshake = cfg_wr_en && cfg_addr == `IQM_ADDR_HANDSHAKE;
  wire wr_tw0 = cfg_wr_en && cfg_addr == `IQM_ADDR_TW0;
  wire wr_tw1 = cfg_wr_en && cfg_addr == `IQM_ADDR_TW1;
  wire wr_tw2 = cfg_wr_en && cfg_addr == `IQM_ADDR_TW2;
  wire wr_tw3 = cfg_wr_en && cfg_addr == `IQM_ADDR_TW3;
  wire wr_angle0 = cfg_wr_en && cfg_addr == `IQM_ADDR_ANGLE0;
  wire wr_angle1 = cfg_wr_en && cfg_addr == `IQM_ADDR_ANGLE1;
  wire wr_iofs0 = cfg_wr_en && cfg_addr == `IQM_ADDR_IOFS0;
  wire wr_iofs1 = cfg_wr_en && cfg_addr == `IQM_ADDR_IOFS1;
  wire wr_qofs0 = cfg_wr_en && cfg_addr == `IQM_ADDR_QOFS0;
  wire wr_qofs1 = cfg_wr_en && cfg_addr == `IQM_ADDR_QOFS1;
  wire wr_igain = cfg_wr_en && cfg_addr == `IQM_ADDR_IGAIN;
  wire wr_qgain = cfg_wr_en && cfg_addr == `IQM_ADDR_QGAIN;

  // pending word, low byte at the lowest offset
  wire [31:0] tuning_word_next = {wr_tw3 ? cfg_wr_data : tuning_word_reg[31:24],
                                  wr_tw2 ? cfg_wr_data : tuning_word_reg[23:16],
                                  wr_tw1 ? cfg_wr_data : tuning_word_reg[15:8],
                                  wr_tw0 ? cfg_wr_data : tuning_word_reg[7:0]};
  wire [12:0] angle_next = {wr_angle1 ? cfg_wr_data[4:0] : quadrature_angle_code_reg[12:8],
                            wr_angle0 ? cfg_wr_data : quadrature_angle_code_reg[7:0]};
  wire [15:0] i_offset_next = {wr_iofs1 ? cfg_wr_data : i_offset_value_reg[15:8],
                               wr_iofs0 ? cfg_wr_data : i_offset_value_reg[7:0]};
  wire [15:0] q_offset_next = {wr_qofs1 ? cfg_wr_data : q_offset_value_reg[15:8],
                               wr_qofs0 ? cfg_wr_data : q_offset_value_reg[7:0]};
  wire [5:0] i_gain_next = wr_igain ? cfg_wr_data[5:0] : i_gain_code_reg;
  wire [5:0] q_gain_next = wr_qgain ? cfg_wr_data[5:0] : q_gain_code_reg;

  // software handshake edges of the request bit
  wire sw_rise = wr_handshake && cfg_wr_data[`IQM_BIT_SW_REQ] && !sw_update_request_reg;
  wire sw_fall = wr_handshake && !cfg_wr_data[`IQM_BIT_SW_REQ] && sw_update_request_reg;
  wire sw_request_next = wr_handshake ? cfg_wr_data[`IQM_BIT_SW_REQ] : sw_update_request_reg;
  wire sw_ack_next = sw_rise ? 1'b1 : (sw_fall ? 1'b0 : sw_update_acknowledge_reg);

  // frame trigger only reads the second synchroniser stage
  wire frame_rise = frame_sync_reg && !frame_prev_reg;
  wire frame_osc_sel = frame_cfg_reg[1:0] == `IQM_FRAME_MODE_OSC ||
                       frame_cfg_reg[1:0] == `IQM_FRAME_MODE_BOTH;
  wire frame_cont = frame_cfg_reg[`IQM_BIT_CONT_FRAME];
  wire frame_take = frame_rise && frame_osc_sel && (frame_cont || frame_armed_reg);
  // a config write re-arms one-shot mode; it wins over a disarm
  wire frame_armed_next = wr_frame_cfg ? 1'b1 : (frame_take ? 1'b0 : frame_armed_reg);
  // the set wins over the clear caused by rewriting the frame config
  wire frame_ack_next = frame_take ? 1'b1 :
                        (wr_frame_cfg ? 1'b0 : frame_update_acknowledge_reg);

  // active word changes only on a trigger
  wire [31:0] active_word_next = (sw_rise || frame_take) ? tuning_word_reg :
                                 active_word_reg;
  // wraps modulo 2^32, so a negative word runs the carrier backwards
  wire [31:0] phase_acc_next = phase_acc_reg + active_word_reg;

  // carrier from the top six accumulator bits
  wire [5:0] carrier_phase = phase_acc_reg[31:26];
  wire signed [15:0] carrier_sin = sine_of(carrier_phase);
  wire signed [15:0] carrier_cos = sine_of(carrier_phase + `IQM_QUARTER_STEP);
  wire signed [39:0] osc_i_wide = 40'(in_sample.i) * 40'(carrier_cos)
                                - 40'(in_sample.q) * 40'(carrier_sin);
  wire signed [39:0] osc_q_wide = 40'(in_sample.i) * 40'(carrier_sin)
                                + 40'(in_sample.q) * 40'(carrier_cos);
  iqm_sample_type osc_sample;
  assign osc_sample.i = sat16(osc_i_wide >>> `IQM_CARRIER_SHIFT);
  assign osc_sample.q = sat16(osc_q_wide >>> `IQM_CARRIER_SHIFT);

  // quarter-turn rotation needs negation only, no multiplier
  wire signed [15:0] neg_i = sat16(-40'(in_sample.i));
  wire signed [15:0] neg_q = sat16(-40'(in_sample.q));
  iqm_sample_type coarse_sample;
  assign coarse_sample.i = quarter_reg == 2'h0 ? in_sample.i :
                           quarter_reg == 2'h1 ? neg_q :
                           quarter_reg == 2'h2 ? neg_i : in_sample.q;
  assign coarse_sample.q = quarter_reg == 2'h0 ? in_sample.q :
                           quarter_reg == 2'h1 ? in_sample.i :
                           quarter_reg == 2'h2 ? neg_q : neg_i;
  wire iqm_sample_type mixed_sample = mix_mode == IQM_MIX_COARSE ? coarse_sample :
                                      mix_mode == IQM_MIX_OSC ? osc_sample : in_sample;

  // inverse sinc stage; bypass changes latency by nothing here
  wire [6:0][15:0] i_tap_next = s1_valid_reg ? {i_tap_reg[5:0], s1_sample_reg.i} : i_tap_reg;
  wire [6:0][15:0] q_tap_next = s1_valid_reg ? {q_tap_reg[5:0], s1_sample_reg.q} : q_tap_reg;
  iqm_sample_type fir_sample;
  assign fir_sample.i = fir7(i_tap_next);
  assign fir_sample.q = fir7(q_tap_next);
  wire iqm_sample_type s2_next = rolloff_comp_enable_reg ? fir_sample : s1_sample_reg;

  // gain stage
  iqm_sample_type s3_next;
  assign s3_next.i = gain_of(s2_sample_reg.i, i_gain_code_reg);
  assign s3_next.q = gain_of(s2_sample_reg.q, q_gain_code_reg);

  // small-angle tilt of Q toward I, one code about 2^-14 rad
  wire signed [39:0] tilt_wide = (40'(s3_sample_reg.i) *
                                  40'(signed'(quadrature_angle_code_reg))) >>> `IQM_ANGLE_SHIFT;
  iqm_sample_type s4_next;
  assign s4_next.i = sat16(40'(s3_sample_reg.i) +
                           40'(signed'(i_offset_value_reg)));
  assign s4_next.q = sat16(40'(s3_sample_reg.q) + tilt_wide +
                           40'(signed'(q_offset_value_reg)));

  // read mux, unmapped offsets read zero
  logic [7:0] rd_word;
  always_comb begin
    case (cfg_addr)
      `IQM_ADDR_FRAME_CFG: rd_word = {5'h00, frame_cfg_reg};
      `IQM_ADDR_ROLLOFF: rd_word = {rolloff_comp_enable_reg, 7'h00};
      `IQM_ADDR_HANDSHAKE: rd_word = {1'b0, frame_update_acknowledge_reg, 4'h0,
                                      sw_update_acknowledge_reg, sw_update_request_reg};
      `IQM_ADDR_TW0: rd_word = tuning_word_reg[7:0];
      `IQM_ADDR_TW1: rd_word = tuning_word_reg[15:8];
      `IQM_ADDR_TW2: rd_word = tuning_word_reg[23:16];
      `IQM_ADDR_TW3: rd_word = tuning_word_reg[31:24];
      `IQM_ADDR_ANGLE0: rd_word = quadrature_angle_code_reg[7:0];
      `IQM_ADDR_ANGLE1: rd_word = {3'h0, quadrature_angle_code_reg[12:8]};
      `IQM_ADDR_IOFS0: rd_word = i_offset_value_reg[7:0];
      `IQM_ADDR_IOFS1: rd_word = i_offset_value_reg[15:8];
      `IQM_ADDR_QOFS0: rd_word = q_offset_value_reg[7:0];
      `IQM_ADDR_QOFS1: rd_word = q_offset_value_reg[15:8];
      `IQM_ADDR_IGAIN: rd_word = {2'h0, i_gain_code_reg};
      `IQM_ADDR_QGAIN: rd_word = {2'h0, q_gain_code_reg};
      default: rd_word = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      frame_cfg_reg <= 3'h0;
      rolloff_comp_enable_reg <= 1'b0;
      sw_update_request_reg <= 1'b0;
      sw_update_acknowledge_reg <= 1'b0;
      frame_update_acknowledge_reg <= 1'b0;
      frame_armed_reg <= 1'b1;
      tuning_word_reg <= 32'h00000000;
      active_word_reg <= 32'h00000000;
      phase_acc_reg <= 32'h00000000;
      quadrature_angle_code_reg <= 13'h0000;
      i_offset_value_reg <= 16'h0000;
      q_offset_value_reg <= 16'h0000;
      i_gain_code_reg <= `IQM_GAIN_RESET;
      q_gain_code_reg <= `IQM_GAIN_RESET;
      cfg_rd_data_reg <= 8'h00;
    end else begin
      frame_cfg_reg <= wr_frame_cfg ? cfg_wr_data[2:0] : frame_cfg_reg;
      rolloff_comp_enable_reg <= wr_rolloff ? cfg_wr_data[`IQM_BIT_ROLLOFF_EN] :
                                 rolloff_comp_enable_reg;
      sw_update_request_reg <= sw_request_next;
      sw_update_acknowledge_reg <= sw_ack_next;
      frame_update_acknowledge_reg <= frame_ack_next;
      frame_armed_reg <= frame_armed_next;
      tuning_word_reg <= tuning_word_next;
      active_word_reg <= active_word_next;
      phase_acc_reg <= phase_acc_next;
      quadrature_angle_code_reg <= angle_next;
      i_offset_value_reg <= i_offset_next;
      q_offset_value_reg <= q_offset_next;
      i_gain_code_reg <= i_gain_next;
      q_gain_code_reg <= q_gain_next;
      cfg_rd_data_reg <= rd_word;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      frame_meta_reg <= 1'b0;
      frame_sync_reg <= 1'b0;
      frame_prev_reg <= 1'b0;
    end else begin
      frame_meta_reg <= frame_in;
      frame_sync_reg <= frame_meta_reg;
      frame_prev_reg <= frame_sync_reg;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      quarter_reg <= 2'h0;
      s1_valid_reg <= 1'b0;
      s2_valid_reg <= 1'b0;
      s3_valid_reg <= 1'b0;
      s4_valid_reg <= 1'b0;
      s1_sample_reg <= '0;
      s2_sample_reg <= '0;
      s3_sample_reg <= '0;
      s4_sample_reg <= '0;
      i_tap_reg <= '0;
      q_tap_reg <= '0;
    end else begin
      quarter_reg <= quarter_reg + 2'h1;
      s1_valid_reg <= in_valid;
      s2_valid_reg <= s1_valid_reg;
      s3_valid_reg <= s2_valid_reg;
      s4_valid_reg <= s3_valid_reg;
      s1_sample_reg <= in_valid ? mixed_sample : s1_sample_reg;
      s2_sample_reg <= s1_valid_reg ? s2_next : s2_sample_reg;
      s3_sample_reg <= s2_valid_reg ? s3_next : s3_sample_reg;
      s4_sample_reg <= s3_valid_reg ? s4_next : s4_sample_reg;
      i_tap_reg <= i_tap_next;
      q_tap_reg <= q_tap_next;
    end
  end

  assign cfg_rd_data = cfg_rd_data_reg;
  assign out_valid = s4_valid_reg;
  assign out_sample = s4_sample_reg;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  a_coarse_quarter_turn: assert property (
    in_valid && mix_mode == IQM_MIX_COARSE && quarter_reg == 2'h1
    |=> s1_sample_reg.q == $past(in_sample.i))
    else $error("coarse mixer quarter rotation wrong");
  a_sw_update_load: assert property (
    sw_rise |=> active_word_reg == $past(tuning_word_reg) && sw_update_acknowledge_reg)
    else $error("request rise did not load word and acknowledge");
  a_word_held_pending: assert property (
    !sw_rise && !frame_take |=> $stable(active_word_reg))
    else $error("active word changed without trigger");
  a_ack_clear_fall: assert property (
    sw_fall |=> !sw_update_acknowledge_reg ##1 (!sw_update_acknowledge_reg || $past(sw_rise)))
    else $error("acknowledge not cleared on request fall");
  a_frame_mode_gate: assert property (
    frame_take |-> frame_osc_sel && $rose(frame_sync_reg))
    else $error("frame update outside oscillator frame mode");
  a_frame_one_shot: assert property (
    frame_take && !frame_cont && !wr_frame_cfg |=> !frame_armed_reg)
    else $error("one-shot frame mode stayed armed");
  a_frame_ack_set: assert property (
    frame_take |=> frame_update_acknowledge_reg && active_word_reg == $past(tuning_word_reg))
    else $error("frame update not acknowledged");
  a_phase_step: assert property (
    1'b1 |=> phase_acc_reg == $past(phase_acc_reg) + $past(active_word_reg))
    else $error("accumulator did not advance by active word");
  a_rolloff_bypass: assert property (
    s1_valid_reg && !rolloff_comp_enable_reg |=> s2_sample_reg == $past(s1_sample_reg))
    else $error("inverse sinc not bypassed when disabled");
  a_gain_unity_pass: assert property (
    s2_valid_reg && i_gain_code_reg == `IQM_GAIN_RESET && q_gain_code_reg == `IQM_GAIN_RESET
    |=> s3_sample_reg == $past(s2_sample_reg))
    else $error("unity gain code altered sample");
  a_fixed_latency: assert property (
    in_valid |-> ##4 out_valid)
    else $error("pipeline latency not four cycles");

  c_sw_update: cover property (sw_rise ##[1:20] sw_fall);
  c_frame_update: cover property (frame_take && !frame_cont);
  c_fir_active: cover property (rolloff_comp_enable_reg && s2_valid_reg);
  c_osc_output: cover property (mix_mode == IQM_MIX_OSC && out_valid);

endmodule

/* File: verif/iqm_src.sv */
// upstream sample source model feeding the quadrature path
`timescale 1ns/1ps
module iqm_src import iqm_pkg::*; (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // bench request
  input wire logic send,
  input iqm_sample_type send_data,
  // stream toward the path
  output logic in_valid,
  output iqm_sample_type in_sample
);
  iqm_sample_type last_reg;
  // idle cycles show inverted stale data so it is never mistaken for a sample
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      in_valid <= 1'b0;
      in_sample <= '0;
      last_reg <= '0;
    end else if (send) begin
      in_valid <= 1'b1;
      in_sample <= send_data;
      last_reg <= send_data;
    end else begin
      in_valid <= 1'b0;
      in_sample <= ~last_reg;
    end
  end
endmodule

/* File: verif/iqm_path_bench.sv */
// self-checking bench for the quadrature correction path
`timescale 1ns/1ps
module iqm_path_bench import iqm_pkg::*;;
  logic ref_clk, rstn, cfg_wr_en, frame_in, in_valid, out_valid, send;
  logic [7:0] cfg_addr, cfg_wr_data, cfg_rd_data;
  iqm_mix_mode_type mix_mode;
  iqm_sample_type in_sample, out_sample, send_data;
  iqm_sample_type outq[$];
  logic [15:0] fq[$];
  logic [7:0] ra[7] = '{8'h3F, 8'h40, 8'h27, 8'h3B, 8'h30, 8'h22, 8'h50};
  logic [7:0] re[7] = '{8'h20, 8'h20, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [15:0] fe[7] = '{16'hFFFF, 16'h0004, 16'hFFF0, 16'h00C0, 16'hFFF0, 16'h0004, 16'hFFFF};
  int num_errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  iqm_path i_iqm_path(.ref_clk(ref_clk), .rstn(rstn), .cfg_wr_en(cfg_wr_en),
    .cfg_addr(cfg_addr), .cfg_wr_data(cfg_wr_data), .cfg_rd_data(cfg_rd_data),
    .frame_in(frame_in), .mix_mode(mix_mode), .in_valid(in_valid),
    .in_sample(in_sample), .out_valid(out_valid), .out_sample(out_sample));
  iqm_src i_iqm_src(.ref_clk(ref_clk), .rstn(rstn), .send(send), .send_data(send_data),
    .in_valid(in_valid), .in_sample(in_sample));
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // outputs sampled before the edge's own updates land
  always @(posedge ref_clk) begin
    if (out_valid === 1'b1) outq.push_back(out_sample);
  end
  // ceiling well above the few hundred cycles the sequence needs
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      test_done();
    end
  end
  task automatic test_done;
    if (num_errors == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    cfg_wr_en <= 1'b1;
    cfg_addr <= a;
    cfg_wr_data <= d;
    @(posedge ref_clk);
    cfg_wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    cfg_addr <= a;
    @(posedge ref_clk);
    #1 chk({8'h00, cfg_rd_data}, {8'h00, exp});
  endtask
  task automatic wr16(input logic [7:0] a, input logic [15:0] v);
    wr(a, v[7:0]);
    wr(a + 8'h01, v[15:8]);
  endtask
  // back-to-back samples, then wait a bounded time for all of them
  task automatic run(input logic [15:0] iv[$], input logic [15:0] qv);
    outq.delete();
    foreach (iv[k]) begin
      @(posedge ref_clk);
      send <= 1'b1;
      send_data <= '{iv[k], qv};
    end
    @(posedge ref_clk);
    send <= 1'b0;
    for (int k = 0; k < 30 && outq.size() < iv.size(); k++) @(posedge ref_clk);
    chk(16'(outq.size()), 16'(iv.size()));
  endtask
  // frame pin high for three clocks, then time for the synchroniser to settle
  task automatic pulse;
    @(posedge ref_clk);
    frame_in <= 1'b1;
    repeat (3) @(posedge ref_clk);
    frame_in <= 1'b0;
    repeat (8) @(posedge ref_clk);
  endtask
  // quarter-turn steps: next I equals minus current Q
  task automatic rot;
    for (int n = 0; n < 3; n++) chk(outq[n+1].i, -outq[n].q);
    chk(outq[2].i, -outq[0].i);
  endtask
  initial begin
    rstn = 1'b0;
    cfg_wr_en = 1'b0;
    cfg_addr = 8'h00;
    cfg_wr_data = 8'h00;
    frame_in = 1'b0;
    mix_mode = IQM_MIX_BYPASS;
    send = 1'b0;
    send_data = '0;
    repeat (20) @(posedge ref_clk);
    rstn <= 1'b1;
    for (int k = 0; k < 7; k++) rd(ra[k], re[k]);
    wr(8'h3F, 8'hFF);
    rd(8'h3F, 8'h3F);
    wr(8'h3F, 8'h20);
    run('{16'h04D2}, 16'hFFC9);
    chk(outq[0].i, 16'h04D2);
    chk(outq[0].q, 16'hFFC9);
    wr16(8'h3B, 16'h0100);
    wr16(8'h3D, 16'hFFFF);
    run('{16'h7FF0}, 16'h0000);
    chk(outq[0].i, 16'h7FFF);
    chk(outq[0].q, 16'hFFFF);
    wr16(8'h3B, 16'h0000);
    wr16(8'h3D, 16'h0000);
    wr(8'h3F, 8'h10);
    wr(8'h40, 8'h3F);
    run('{16'd1000}, 16'd1000);
    chk(outq[0].i, 16'h01F4);
    chk(outq[0].q, 16'h07B0);
    wr(8'h3F, 8'h20);
    wr(8'h40, 8'h20);
    for (int k = 0; k < 2; k++) begin
      wr16(8'h37, k ? 16'h1000 : 16'h0FFF);
      run('{16'h4000}, 16'h0000);
      chk(outq[0].q, k ? 16'hF000 : 16'h0FFF);
    end
    wr16(8'h37, 16'h0000);
    mix_mode <= IQM_MIX_COARSE;
    run('{16'd1000, 16'd1000, 16'd1000, 16'd1000}, 16'h0000);
    rot();
    wr16(8'h31, 16'h0000);
    wr16(8'h33, 16'h4000);
    rd(8'h34, 8'h40);
    mix_mode <= IQM_MIX_OSC;
    run('{16'h4000}, 16'h0000);
    chk(outq[0].i, 16'h3FFF);
    wr(8'h30, 8'h01);
    rd(8'h30, 8'h03);
    run('{16'h4000, 16'h4000, 16'h4000, 16'h4000}, 16'h0000);
    rot();
    wr(8'h30, 8'h00);
    rd(8'h30, 8'h00);
    // a zero word freezes the carrier, so a frame load shows as equal outputs
    wr(8'h34, 8'h00);
    wr(8'h22, 8'h01);
    pulse();
    rd(8'h30, 8'h40);
    run('{16'h4000, 16'h4000}, 16'h0000);
    chk(outq[1].i, outq[0].i);
    // one-shot: a second frame edge must leave the pending quarter-turn word unused
    wr(8'h34, 8'h40);
    pulse();
    run('{16'h4000, 16'h4000}, 16'h0000);
    chk(outq[1].i, outq[0].i);
    mix_mode <= IQM_MIX_BYPASS;
    wr(8'h27, 8'h80);
    rd(8'h27, 8'h80);
    repeat (7) fq.push_back(16'h0000);
    fq.push_back(16'h0100);
    repeat (7) fq.push_back(16'h0000);
    run(fq, 16'h0000);
    for (int k = 0; k < 7; k++) chk(outq[k+7].i, fe[k]);
    test_done();
  end
endmodule
